// *** rtl/ddb_dev.sv ***
// Read data FIFO and DDR2 command decoder with bank tracking and read bursts.
// Assumes the command pins and ck come from outside clk's domain, ck much slower than clk.
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Collapsing FIFO: the head entry is a flop, so its outputs are registered.
module ddb_fifo #(
	parameter int W = 16,
	parameter int D = 8
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	logic [W-1:0] mem_r [D];
	logic [D-1:0] vld_r;
	logic [D:0]   vld_x_w;
	logic [D-1:0] sh_w;
	logic         pop_w;
	logic         push_w;

	assign pop_w     = vld_r[0] & out_ready;
	assign in_ready  = ~vld_r[D-1];
	assign push_w    = in_valid & in_ready;
	assign out_valid = vld_r[0];
	assign out_data  = mem_r[0];
	// The entry past the last one reads as empty, so the tail shifts in nothing.
	assign vld_x_w   = {1'b0, vld_r};

	genvar i;
	generate
		for (i = 0; i < D; i++) begin : g_ent
			logic take_w;
			assign sh_w[i] = pop_w ? vld_x_w[i+1] : vld_r[i];
			if (i == 0) begin : g_first
				assign take_w = push_w & ~sh_w[0];
			end else begin : g_rest
				assign take_w = push_w & ~sh_w[i] & sh_w[i-1];
			end
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					vld_r[i] <= 1'b0;
					mem_r[i] <= '0;
				end else begin
					vld_r[i] <= sh_w[i] | take_w;
					if (take_w) begin
						mem_r[i] <= in_data;
					end else if (pop_w && i < D-1) begin
						mem_r[i] <= mem_r[(i+1) % D];
					end
				end
			end
		end
	endgenerate
endmodule // ddb_fifo

module ddb_dev #(
	parameter logic [7:0] TRP_CK  = 8'h03,
	parameter logic [7:0] TRTP_CK = 8'h02,
	parameter logic [7:0] TWR_CK  = 8'h03,
	parameter int         NPEND   = 8,
	parameter int         FIFO_D  = 8
) (
	input  wire logic                         clk,
	input  wire logic                         reset_n,
	input  wire logic                         ck_pin,
	input  wire logic                         cs_n_pin,
	input  wire logic                         ras_n_pin,
	input  wire logic                         cas_n_pin,
	input  wire logic                         we_n_pin,
	input  wire logic [ddb_pkg::BA_W-1:0]     ba_pin,
	input  wire logic [ddb_pkg::ADDR_W-1:0]   addr_pin,
	output logic [ddb_pkg::DATA_W-1:0]        rd_data,
	output logic                              rd_valid,
	input  wire logic                         rd_ready,
	output logic [ddb_pkg::NBANK-1:0]         bank_idle,
	output logic [ddb_pkg::NBANK-1:0]         bank_open,
	output logic [2:0]                        mode_cl,
	output logic [2:0]                        mode_al,
	output logic                              burst_busy
);
	localparam int PW = $clog2(NPEND);
	localparam int PINS = 4 + ddb_pkg::BA_W + ddb_pkg::ADDR_W;

	// ============================================================
	// Reset release and pin synchronisers
	logic [1:0]      rst_s_r;
	logic            rst_n;
	logic [2:0]      ck_s_r;
	logic [PINS-1:0] pin_s1_r;
	logic [PINS-1:0] pin_s2_r;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) rst_s_r <= 2'h0;
		else          rst_s_r <= {rst_s_r[0], 1'b1};
	end
	assign rst_n = rst_s_r[1];

	// Pins and ck share the same two-stage depth, so a command stays aligned with its ck edge.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ck_s_r   <= 3'h0;
			pin_s1_r <= '1;
			pin_s2_r <= '1;
		end else begin
			ck_s_r   <= {ck_s_r[1:0], ck_pin};
			pin_s1_r <= {cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin, ba_pin, addr_pin};
			pin_s2_r <= pin_s1_r;
		end
	end

	// ============================================================
	// Command decode
	logic                         ck_rise_w;
	logic                         ck_edge_w;
	logic                         sel_w;
	logic [2:0]                   cmd_w;
	logic [ddb_pkg::BA_W-1:0]     cba_w;
	logic [ddb_pkg::ADDR_W-1:0]   cad_w;
	logic                         is_mode_load_w;
	logic                         is_pre_w;
	logic                         is_act_w;
	logic                         is_rd_w;
	logic                         is_wr_w;
	logic                         ap_w;

	assign ck_rise_w = ck_s_r[1] & ~ck_s_r[2];
	assign ck_edge_w = ck_s_r[1] ^ ck_s_r[2];
	assign sel_w     = ck_rise_w & ~pin_s2_r[PINS-1];
	assign cmd_w     = pin_s2_r[PINS-2:PINS-4];
	assign cba_w     = pin_s2_r[ddb_pkg::ADDR_W +: ddb_pkg::BA_W];
	assign cad_w     = pin_s2_r[ddb_pkg::ADDR_W-1:0];
	// The all-high code matches none of these, so NOP loads no mode register and moves no bank out of idle or active.
	assign is_mode_load_w = sel_w & (cmd_w == ddb_pkg::MODE_REGISTER_LOAD_CMD);
	assign is_pre_w  = sel_w & (cmd_w == ddb_pkg::CMD_PRE);
	assign is_act_w  = sel_w & (cmd_w == ddb_pkg::CMD_ACT);
	assign is_rd_w   = sel_w & (cmd_w == ddb_pkg::CMD_RD);
	assign is_wr_w   = sel_w & (cmd_w == ddb_pkg::CMD_WR);
	assign ap_w      = cad_w[ddb_pkg::AP_BIT];

	// ============================================================
	// Mode registers and derived latencies
	logic [ddb_pkg::ADDR_W-1:0] mr_r [ddb_pkg::NMR];
	logic [3:0]                 bl_w;
	logic [3:0]                 half_w;
	logic [3:0]                 rl_w;
	logic [7:0]                 rd_ap_w;
	logic [7:0]                 wr_ap_w;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int m = 0; m < ddb_pkg::NMR; m++) mr_r[m] <= ddb_pkg::MR_RST;
			mr_r[0] <= ddb_pkg::MR0_RST;
			mr_r[1] <= ddb_pkg::MR1_RST;
		end else if (is_mode_load_w) begin
			mr_r[cba_w] <= cad_w;
		end
	end
	assign mode_cl = mr_r[0][ddb_pkg::CL_LSB +: 3];
	assign mode_al = mr_r[1][ddb_pkg::AL_LSB +: 3];
	assign bl_w    = (mr_r[0][ddb_pkg::BL_LSB +: 3] == ddb_pkg::BL8_CODE) ? ddb_pkg::BL8 : ddb_pkg::BL4;
	assign half_w  = {1'b0, bl_w[3:1]};
	assign rl_w    = {1'b0, mode_al} + {1'b0, mode_cl};
	assign rd_ap_w = {5'h0, mode_al} + {4'h0, half_w} + TRTP_CK - 8'h02;
	assign wr_ap_w = {4'h0, rl_w} - 8'h01 + {4'h0, half_w} + TWR_CK;

	// ============================================================
	// Bank state machines
	logic [ddb_pkg::NBANK-1:0]  idle_w;
	logic [ddb_pkg::NBANK-1:0]  open_w;
	logic [ddb_pkg::ADDR_W-1:0] row_w [ddb_pkg::NBANK];
	logic                       bst_v_r;
	logic [ddb_pkg::BA_W-1:0]   bst_ba_w;

	genvar b;
	generate
		for (b = 0; b < ddb_pkg::NBANK; b++) begin : g_bank
			ddb_pkg::ddb_bank_t         st_r;
			logic [ddb_pkg::ADDR_W-1:0] row_r;
			logic [7:0]                 tmr_r;
			logic                       hit_w;
			assign hit_w = (int'(cba_w) == b);
			// Commands to other banks pass here untouched while this one auto-precharges.
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					st_r  <= ddb_pkg::DDB_IDLE;
					row_r <= '0;
					tmr_r <= 8'h00;
				end else if (ck_rise_w) begin
					case (st_r)
						ddb_pkg::DDB_IDLE: begin
							if (is_act_w && hit_w) begin
								st_r  <= ddb_pkg::DDB_ACTIVE;
								row_r <= cad_w;
							end
						end
						ddb_pkg::DDB_ACTIVE: begin
							if (is_pre_w && (hit_w || ap_w)) begin
								st_r  <= ddb_pkg::DDB_PRECH;
								tmr_r <= TRP_CK;
							end else if ((is_rd_w || is_wr_w) && hit_w && ap_w) begin
								st_r  <= ddb_pkg::DDB_APWAIT;
								tmr_r <= is_rd_w ? rd_ap_w : wr_ap_w;
							end
						end
						ddb_pkg::DDB_APWAIT: begin
							if (tmr_r <= 8'h01) begin
								st_r  <= ddb_pkg::DDB_PRECH;
								tmr_r <= TRP_CK;
							end else begin
								tmr_r <= tmr_r - 8'h01;
							end
						end
						ddb_pkg::DDB_PRECH: begin
							if (tmr_r <= 8'h01) st_r <= ddb_pkg::DDB_IDLE;
							else                tmr_r <= tmr_r - 8'h01;
						end
						default: st_r <= ddb_pkg::DDB_IDLE;
					endcase
				end
			end
			assign idle_w[b] = (st_r == ddb_pkg::DDB_IDLE) && !(bst_v_r && int'(bst_ba_w) == b);
			assign open_w[b] = (st_r == ddb_pkg::DDB_ACTIVE) || (st_r == ddb_pkg::DDB_APWAIT);
			assign row_w[b]  = row_r;
		end
	endgenerate

	// ============================================================
	// Read latency queue: one slot per READ still waiting for its latency
	logic                      pq_v_r   [NPEND];
	logic [3:0]                pq_cnt_r [NPEND];
	logic [ddb_pkg::DATA_W-1:0] pq_wd_r [NPEND];
	logic [PW-1:0]             pq_rd_r;
	logic [PW-1:0]             pq_wr_r;
	logic                      start_w;
	logic [ddb_pkg::DATA_W-1:0] new_wd_w;

	assign new_wd_w = {cba_w, row_w[cba_w][3:0], cad_w[ddb_pkg::COL_W-1:0]};
	assign start_w  = ck_rise_w & pq_v_r[pq_rd_r] & (pq_cnt_r[pq_rd_r] == 4'h1);

	genvar q;
	generate
		for (q = 0; q < NPEND; q++) begin : g_pend
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					pq_v_r[q]   <= 1'b0;
					pq_cnt_r[q] <= 4'h0;
					pq_wd_r[q]  <= '0;
				end else if (is_rd_w && int'(pq_wr_r) == q) begin
					pq_v_r[q]   <= 1'b1;
					pq_cnt_r[q] <= rl_w;
					pq_wd_r[q]  <= new_wd_w;
				end else if (start_w && int'(pq_rd_r) == q) begin
					pq_v_r[q] <= 1'b0;
				end else if (ck_rise_w && pq_v_r[q]) begin
					pq_cnt_r[q] <= pq_cnt_r[q] - 4'h1;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pq_rd_r <= '0;
			pq_wr_r <= '0;
		end else begin
			if (is_rd_w) pq_wr_r <= pq_wr_r + 1'b1;
			if (start_w) pq_rd_r <= pq_rd_r + 1'b1;
		end
	end

	// ============================================================
	// Burst generator: one element owed per ck edge, pushed when the FIFO has room
	logic [3:0]                 bst_left_r;
	logic [ddb_pkg::DATA_W-1:0] bst_wd_r;
	logic                       owe_r;
	logic                       fifo_rdy_w;
	logic                       push_w;
	logic                       last_w;

	assign bst_ba_w = bst_wd_r[ddb_pkg::DATA_W-1 -: ddb_pkg::BA_W];
	assign push_w   = owe_r & bst_v_r & fifo_rdy_w;
	assign last_w   = push_w & (bst_left_r == 4'h1);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bst_v_r    <= 1'b0;
			bst_left_r <= 4'h0;
			bst_wd_r   <= '0;
			owe_r      <= 1'b0;
		end else if (start_w) begin
			bst_v_r    <= 1'b1;
			bst_left_r <= bl_w;
			bst_wd_r   <= pq_wd_r[pq_rd_r];
			owe_r      <= 1'b1;
		end else begin
			if (push_w) begin
				bst_left_r <= bst_left_r - 4'h1;
				bst_wd_r   <= bst_wd_r + 1'b1;
			end
			if (last_w) bst_v_r <= 1'b0;
			owe_r <= (owe_r & ~push_w) | (ck_edge_w & bst_v_r & ~last_w);
		end
	end

	ddb_fifo #(
		.W (ddb_pkg::DATA_W),
		.D (FIFO_D)
	) u_fifo (
		.clk       (clk),
		.rst_n     (rst_n),
		.in_valid  (push_w),
		.in_ready  (fifo_rdy_w),
		.in_data   (bst_wd_r),
		.out_valid (rd_valid),
		.out_ready (rd_ready),
		.out_data  (rd_data)
	);

	// ============================================================
	// Status
	logic any_pend_w;
	always_comb begin
		any_pend_w = 1'b0;
		for (int k = 0; k < NPEND; k++) any_pend_w = any_pend_w | pq_v_r[k];
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bank_idle  <= '1;
			bank_open  <= '0;
			burst_busy <= 1'b0;
		end else begin
			bank_idle  <= idle_w;
			bank_open  <= open_w;
			burst_busy <= bst_v_r | any_pend_w;
		end
	end
endmodule // ddb_dev

`default_nettype wire

// *** rtl/ddb_pkg.sv ***
// Shared constants for the DDR2 command-side device model.
// Assumes nothing of its surroundings; used by rtl/ddb_dev.sv and by the bench.
package ddb_pkg;
	// ============================================================
	// Pin widths and command codes {ras_n, cas_n, we_n}
	localparam int        BA_W        = 2;
	localparam int        ADDR_W      = 13;
	localparam int        COL_W       = 10;
	localparam int        NBANK       = 4;
	localparam int        NMR         = 4;
	localparam int        DATA_W      = 16;
	localparam int        AP_BIT      = 10;
	localparam logic [2:0] MODE_REGISTER_LOAD_CMD = 3'h0;
	localparam logic [2:0] CMD_PRE    = 3'h2;
	localparam logic [2:0] CMD_ACT    = 3'h3;
	localparam logic [2:0] CMD_WR     = 3'h4;
	localparam logic [2:0] CMD_RD     = 3'h5;
	// ============================================================
	// Mode register fields and reset values
	localparam int         BL_LSB     = 0;
	localparam int         CL_LSB     = 4;
	localparam int         AL_LSB     = 3;
	localparam logic [2:0] BL8_CODE   = 3'h3;
	localparam logic [3:0] BL4        = 4'h4;
	localparam logic [3:0] BL8        = 4'h8;
	localparam logic [12:0] MR0_RST   = 13'h0032;
	localparam logic [12:0] MR1_RST   = 13'h0000;
	localparam logic [12:0] MR_RST    = 13'h0000;
	// ============================================================
	// Per-bank state
	typedef enum logic [3:0] {
		DDB_IDLE   = 4'h1,
		DDB_ACTIVE = 4'h2,
		DDB_APWAIT = 4'h4,
		DDB_PRECH  = 4'h8
	} ddb_bank_t;
endpackage

// *** tb/ddb_ctl_model.sv ***
// Memory controller model: free-running ck and one command per call of issue.
// Assumes the bench raises run only once the device is out of reset.
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Controller
module ddb_ctl_model (
	input  wire logic  run,
	output logic       ck,
	output logic       cs_n,
	output logic       ras_n,
	output logic       cas_n,
	output logic       we_n,
	output logic [1:0] ba,
	output logic [12:0] addr
);
	initial begin
		ck = 1'b0;
		cs_n = 1'b1;
		{ras_n, cas_n, we_n} = 3'h7;
		ba = 2'h0;
		addr = 13'h0000;
		wait (run === 1'b1);
		forever #200 ck = ~ck;
	end
	// Every command is followed by a full ck of deselect, so rises are two ck apart,
	// which covers mode, activate, row-to-row and concurrent precharge spacing,
	// and a write-to-read gap of at most two ck.
	task issue(input logic sel_n, input logic [2:0] c, input logic [1:0] b, input logic [12:0] a);
		@(negedge ck);
		cs_n = sel_n;
		{ras_n, cas_n, we_n} = c;
		ba = b;
		addr = a;
		@(posedge ck);
		@(negedge ck);
		// Released lines show the inverse so a stale value cannot pass.
		cs_n = 1'b1;
		{ras_n, cas_n, we_n} = ~c;
		ba = ~b;
		addr = ~a;
	endtask
endmodule // ddb_ctl_model
`default_nettype wire

// *** tb/ddb_dev_properties.sv ***
// Concurrent checks on the ports of ddb_dev, attached by bind.
// Assumes one clk domain and the command pins held at least a ck period.
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Checker
module ddb_dev_props (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        cs_n_pin,
	input  wire logic        ras_n_pin,
	input  wire logic        cas_n_pin,
	input  wire logic        we_n_pin,
	input  wire logic [15:0] rd_data,
	input  wire logic        rd_valid,
	input  wire logic        rd_ready,
	input  wire logic [3:0]  bank_idle,
	input  wire logic [3:0]  bank_open,
	input  wire logic [2:0]  mode_cl,
	input  wire logic [2:0]  mode_al,
	input  wire logic        burst_busy
);
	logic [7:0] since_row_r;
	logic [7:0] since_row_nxt;
	// A mode change, a row opening or a bank leaving idle may only follow shortly after a row or mode command was on the pins.
	assign since_row_nxt = (!cs_n_pin && !ras_n_pin) ? 8'h00 : (since_row_r == 8'hff) ? 8'hff : since_row_r + 8'h01;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) since_row_r <= 8'hff;
		else since_row_r <= since_row_nxt;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	property p_deselect; cs_n_pin [*8] |=> $stable(mode_cl) && $stable(mode_al); endproperty
	a_deselect: assert property (p_deselect) else $error("mode changed while deselected");
	property p_nop; (!cs_n_pin && ras_n_pin && cas_n_pin && we_n_pin) [*8] |=> $stable(mode_cl); endproperty
	a_nop: assert property (p_nop) else $error("mode changed on no-operation");
	property p_mode_cmd; $changed(mode_cl) || $changed(mode_al) |-> since_row_r < 8'h08; endproperty
	a_mode_cmd: assert property (p_mode_cmd) else $error("mode changed without load");
	property p_open_cmd; |(bank_open & ~$past(bank_open)) |-> since_row_r < 8'h08; endproperty
	a_open_cmd: assert property (p_open_cmd) else $error("row opened without activate");
	property p_idle_fall; |(~bank_idle & $past(bank_idle)) |-> since_row_r < 8'h08; endproperty
	a_idle_fall: assert property (p_idle_fall) else $error("bank left idle without command");
	property p_excl; (bank_open & bank_idle) == 4'h0; endproperty
	a_excl: assert property (p_excl) else $error("bank both open and idle");
	property p_hold; rd_valid && !rd_ready |=> rd_valid && $stable(rd_data); endproperty
	a_hold: assert property (p_hold) else $error("read word lost while stalled");
	property p_quiet; (!burst_busy && !rd_valid) [*4] |=> !rd_valid; endproperty
	a_quiet: assert property (p_quiet) else $error("read data without a burst");
endmodule // ddb_dev_props

bind ddb_dev ddb_dev_props u_props (.clk(clk), .reset_n(reset_n), .cs_n_pin(cs_n_pin), .ras_n_pin(ras_n_pin),
	.cas_n_pin(cas_n_pin), .we_n_pin(we_n_pin), .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready),
	.bank_idle(bank_idle), .bank_open(bank_open), .mode_cl(mode_cl), .mode_al(mode_al), .burst_busy(burst_busy));
`default_nettype wire

// *** tb/tb_ddb_dev.sv ***
// Self-checking bench for ddb_dev driven through the controller model.
// Assumes default design parameters: TRP_CK 3, TRTP_CK 2, TWR_CK 3, FIFO depth 8.
`timescale 1ns/1ps
`default_nettype none
module tb_ddb_dev;
	logic        clk;
	logic        reset_n;
	logic        rd_ready;
	logic        run;
	wire logic   ck, cs_n, ras_n, cas_n, we_n;
	wire logic [1:0] ba;
	wire logic [12:0] addr;
	logic [15:0] rd_data;
	logic        rd_valid, burst_busy;
	logic [3:0]  bank_idle, bank_open;
	logic [2:0]  mode_cl, mode_al;
	int          n_errors = 0;
	int          compares = 0;
	int          cyc = 0;
	ddb_dev DUT (.clk(clk), .reset_n(reset_n), .ck_pin(ck), .cs_n_pin(cs_n), .ras_n_pin(ras_n), .cas_n_pin(cas_n),
		.we_n_pin(we_n), .ba_pin(ba), .addr_pin(addr), .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready),
		.bank_idle(bank_idle), .bank_open(bank_open), .mode_cl(mode_cl), .mode_al(mode_al), .burst_busy(burst_busy));
	ddb_ctl_model u_ctl (.run(run), .ck(ck), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr));
	// ============================================================
	// Tasks
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task tally_and_finish;
		$display("compares=%0d n_errors=%0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			tally_and_finish();
		end
	end
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task cmd(input logic [2:0] c, input logic [1:0] b, input logic [12:0] a);
		u_ctl.issue(1'b0, c, b, a);
		repeat (4) @(negedge clk);
	endtask
	task cks(input int n);
		repeat (n) @(posedge ck);
		repeat (8) @(negedge clk);
	endtask
	task pop(input logic [15:0] exp);
		int k;
		k = 0;
		while (rd_valid !== 1'b1 && k < 400) begin
			@(negedge clk);
			k++;
		end
		chk(rd_data, exp);
		rd_ready = 1'b1;
		@(negedge clk);
		rd_ready = 1'b0;
		// One idle edge keeps a following pop from raising ready in the same step.
		@(negedge clk);
	endtask
	// ============================================================
	// Sequence
	initial begin
		reset_n = 1'b0;
		rd_ready = 1'b0;
		run = 1'b0;
		repeat (20) @(negedge clk);
		reset_n = 1'b1;
		chk(bank_idle, 16'h000f);
		chk({mode_cl, mode_al, bank_open, rd_valid}, 16'h0300);
		repeat (6) @(negedge clk);
		run = 1'b1;
		cmd(ddb_pkg::MODE_REGISTER_LOAD_CMD, 2'h0, 13'h0042);
		cmd(ddb_pkg::MODE_REGISTER_LOAD_CMD, 2'h1, 13'h0008);
		chk({mode_cl, mode_al}, 16'h0021);
		u_ctl.issue(1'b1, ddb_pkg::MODE_REGISTER_LOAD_CMD, 2'h0, 13'h0052);
		cks(1);
		chk(mode_cl, 16'h0004);
		u_ctl.issue(1'b0, 3'h7, 2'h0, 13'h0052);
		cks(1);
		chk({mode_cl, bank_open}, 16'h0040);
		cmd(ddb_pkg::CMD_ACT, 2'h2, 13'h0005);
		chk({bank_open, bank_idle}, 16'h004b);
		u_ctl.issue(1'b0, ddb_pkg::CMD_RD, 2'h2, 13'h0008);
		repeat (4) @(posedge ck);
		repeat (6) @(negedge clk);
		chk({burst_busy, rd_valid}, 16'h0002);
		@(posedge ck);
		repeat (7) @(negedge clk);
		chk(rd_valid, 16'h0001);
		for (int i = 0; i < 4; i++) pop({2'h2, 4'h5, 10'h008 + 10'(i)});
		chk(bank_open, 16'h0004);
		cmd(ddb_pkg::CMD_RD, 2'h2, 13'h0410);
		for (int i = 0; i < 4; i++) pop({2'h2, 4'h5, 10'h010 + 10'(i)});
		cks(8);
		chk({bank_open, bank_idle}, 16'h000f);
		// Two bursts back to back with the consumer stalled fill all eight FIFO places.
		cmd(ddb_pkg::CMD_ACT, 2'h0, 13'h0001);
		cmd(ddb_pkg::CMD_ACT, 2'h1, 13'h0002);
		cmd(ddb_pkg::CMD_RD, 2'h0, 13'h0400);
		cmd(ddb_pkg::CMD_RD, 2'h1, 13'h0020);
		cks(10);
		chk(bank_open, 16'h0002);
		for (int i = 0; i < 4; i++) pop({2'h0, 4'h1, 10'(i)});
		for (int i = 0; i < 4; i++) pop({2'h1, 4'h2, 10'h020 + 10'(i)});
		repeat (3) @(negedge clk);
		chk(rd_valid, 16'h0000);
		cmd(ddb_pkg::CMD_ACT, 2'h3, 13'h0003);
		cmd(ddb_pkg::CMD_WR, 2'h3, 13'h0400);
		cmd(ddb_pkg::CMD_PRE, 2'h1, 13'h0000);
		cks(16);
		chk({bank_open, bank_idle}, 16'h000f);
		// Burst length eight, then one precharge of all banks closes both open rows.
		cmd(ddb_pkg::MODE_REGISTER_LOAD_CMD, 2'h0, 13'h0043);
		cmd(ddb_pkg::CMD_ACT, 2'h0, 13'h0001);
		cmd(ddb_pkg::CMD_ACT, 2'h1, 13'h0002);
		cmd(ddb_pkg::CMD_RD, 2'h0, 13'h0000);
		for (int i = 0; i < 8; i++) pop({2'h0, 4'h1, 10'(i)});
		chk({rd_valid, bank_open}, 16'h0003);
		cmd(ddb_pkg::CMD_PRE, 2'h2, 13'h0400);
		cks(4);
		chk({burst_busy, bank_open, bank_idle}, 16'h000f);
		tally_and_finish();
	end
endmodule // tb_ddb_dev
`default_nettype wire
